// *** hw/ifb_bank.sv ***
// Interrupt flag register four and enable registers zero to two on APB.
// Assumes asynchronous peripheral request inputs and an APB master on pclk.
module ifb_bank
    import ifb_pkg::*;
(
    input  wire logic                       pclk,        // Clock 20 MHz
    input  wire logic                       presetn,     // Async reset, active low
    input  wire logic                       psel,        // APB select
    input  wire logic                       penable,     // APB enable
    input  wire logic                       pwrite,      // APB direction
    input  wire logic [ifb_pkg::ADDR_W-1:0] paddr,       // APB byte address
    input  wire logic [31:0]                pwdata,      // APB write data
    output logic      [31:0]                prdata,      // APB read data
    output logic                            pready,      // APB ready
    output logic                            pslverr,     // APB error
    input  wire logic [15:0]                req_four,    // Requests for flag four
    input  wire logic [15:0]                flags_zero,  // Flags of bank zero
    input  wire logic [15:0]                flags_one,   // Flags of bank one
    input  wire logic [15:0]                flags_two,   // Flags of bank two
    output logic      [15:0]                fwd_zero,    // Forwarded requests zero
    output logic      [15:0]                fwd_one,     // Forwarded requests one
    output logic      [15:0]                fwd_two,     // Forwarded requests two
    output logic      [15:0]                fwd_four,    // Forwarded requests four
    output logic                            irq          // Interrupt, active high
);
    import ifb_pkg::*;

    // Software-visible registers and their next values
    logic [15:0] irq_flags_four;         // Flag register four
    logic [15:0] next_irq_flags_four;    // Next flag register four
    logic [15:0] irq_enables_zero;       // Enable register zero
    logic [15:0] next_irq_enables_zero;  // Next enable register zero
    logic [15:0] irq_enables_one;        // Enable register one
    logic [15:0] next_irq_enables_one;   // Next enable register one
    logic [15:0] irq_enables_two;        // Enable register two
    logic [15:0] next_irq_enables_two;   // Next enable register two
    logic [3:0]  irq_status;             // Sticky bank event status
    logic [3:0]  next_irq_status;        // Next status
    logic [3:0]  irq_mask;               // Status interrupt mask
    logic [3:0]  next_irq_mask;          // Next mask

    // Next values of the registered outputs
    logic [31:0] next_prdata;            // Next read data
    logic        next_pready;            // Next ready
    logic        next_pslverr;           // Next error
    logic        next_irq;               // Next interrupt
    logic [15:0] next_fwd_zero;          // Next forwarded zero
    logic [15:0] next_fwd_one;           // Next forwarded one
    logic [15:0] next_fwd_two;           // Next forwarded two
    logic [15:0] next_fwd_four;          // Next forwarded four

    // Synchronised inputs and decoded bus phases
    logic [15:0] req_sync;               // Flag-four requests on pclk
    logic [15:0] req_rise;               // Flag-four request edges
    logic [15:0] z_sync;                 // Bank zero flags on pclk
    logic [15:0] o_sync;                 // Bank one flags on pclk
    logic [15:0] t_sync;                 // Bank two flags on pclk
    logic        hit;                    // Access phase not yet answered
    logic        wr_ok;                  // Mapped write this cycle
    logic        rd_ok;                  // Read this cycle
    logic        wr_flags4;              // Write to flag four
    logic        wr_status;              // Write to status
    logic        wr_mask;                // Write to mask
    logic [3:0]  events;                 // Status set sources
    logic [15:0] flags_four_view;        // Flag four as laid out

    // Flag four fields by name
    logic        can2_tx_request_flag;   // CAN2 transmit request
    logic        can1_tx_request_flag;   // CAN1 transmit request
    logic        dma_ch7_done_flag;      // DMA channel 7 done
    logic        dma_ch6_done_flag;      // DMA channel 6 done
    logic        uart2_error_flag;       // UART2 error
    logic        uart1_error_flag;       // UART1 error
    logic        pwm_fault_b_flag;       // PWM fault B

    // Requests from other clock domains
    ifb_sync #(.W(16)) u_sync_four (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (req_four),
        .dout    (req_sync)
    );
    ifb_sync #(.W(16)) u_sync_zero (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (flags_zero),
        .dout    (z_sync)
    );
    ifb_sync #(.W(16)) u_sync_one (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (flags_one),
        .dout    (o_sync)
    );
    ifb_sync #(.W(16)) u_sync_two (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (flags_two),
        .dout    (t_sync)
    );

    // Request edges set the flags
    ifb_edge #(.W(16)) u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .level   (req_sync),
        .rise    (req_rise)
    );

    // Flag four fields, each at its own position
    assign can2_tx_request_flag = irq_flags_four[BIT_CAN2_TX];   // R4
    assign can1_tx_request_flag = irq_flags_four[BIT_CAN1_TX];   // R4
    assign dma_ch7_done_flag    = irq_flags_four[BIT_DMA7];      // R4
    assign dma_ch6_done_flag    = irq_flags_four[BIT_DMA6];      // R4
    assign uart2_error_flag     = irq_flags_four[BIT_UART2_ERR]; // R4
    assign uart1_error_flag     = irq_flags_four[BIT_UART1_ERR]; // R4
    assign pwm_fault_b_flag     = irq_flags_four[BIT_FAULT_B];   // R4

    // Spare positions tied low on read-back
    assign flags_four_view = {8'h00, can2_tx_request_flag, can1_tx_request_flag, dma_ch7_done_flag, // R3 R4
                              dma_ch6_done_flag, 1'b0, uart2_error_flag, uart1_error_flag, pwm_fault_b_flag};

    // Decode one access phase
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == OFS_FLAGS4) || (a == OFS_EN0) || (a == OFS_EN1) ||
                    (a == OFS_EN2) || (a == OFS_STATUS) || (a == OFS_MASK);
    endfunction : is_mapped

    // Keep only the implemented bits of a written word
    function automatic logic [15:0] wr_bits(input logic [31:0] d, input logic [15:0] m);
        wr_bits = d[15:0] & m;
    endfunction : wr_bits

    // Widen a register to the bus word, upper half zero
    function automatic logic [31:0] rd_word(input logic [15:0] v);
        rd_word = {16'h0000, v};
    endfunction : rd_word

    // Widen a four-bit register to the bus word
    function automatic logic [31:0] rd_nibble(input logic [3:0] v);
        rd_nibble = {28'h0000000, v};
    endfunction : rd_nibble

    // Write one clears the matching status bits
    function automatic logic [3:0] w1c(input logic [3:0] old, input logic [3:0] d);
        w1c = old & ~d;
    endfunction : w1c

    assign hit   = psel && penable && !pready;
    assign wr_ok = hit && pwrite && is_mapped(paddr);
    assign rd_ok = hit && !pwrite;

    // Per-register write strobes
    assign wr_flags4 = wr_ok && (paddr == OFS_FLAGS4);
    assign wr_status = wr_ok && (paddr == OFS_STATUS);
    assign wr_mask   = wr_ok && (paddr == OFS_MASK);

    // Bank events for status: flag four set, enable banks flagged
    assign events = {|(t_sync & irq_enables_two), |(o_sync & irq_enables_one),
                     |(z_sync & irq_enables_zero), |(req_rise & MASK_FLAGS4)};

    // Flag four: written value, request edges set
    always_comb begin
        next_irq_flags_four = irq_flags_four;
        if (wr_flags4) begin
            next_irq_flags_four = wr_bits(pwdata, MASK_FLAGS4);               // R8 R3
        end
        // Set beats clear
        next_irq_flags_four = next_irq_flags_four | (req_rise & MASK_FLAGS4); // R1 R4
    end

    // Flag four register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flags_four <= RESET_REG;
        end else begin
            irq_flags_four <= next_irq_flags_four;
        end
    end

    // Enable registers: written value, spare bits dropped
    always_comb begin
        next_irq_enables_zero = irq_enables_zero;
        next_irq_enables_one  = irq_enables_one;
        next_irq_enables_two  = irq_enables_two;
        if (wr_ok) begin
            case (paddr)
                OFS_EN0: begin
                    next_irq_enables_zero = wr_bits(pwdata, MASK_EN0); // R5 R3
                end
                OFS_EN1: begin
                    next_irq_enables_one = wr_bits(pwdata, MASK_EN1);  // R6 R3
                end
                OFS_EN2: begin
                    next_irq_enables_two = wr_bits(pwdata, MASK_EN2);  // R7 R3
                end
                default: begin
                    next_irq_enables_zero = irq_enables_zero;
                end
            endcase
        end
    end

    // Enable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enables_zero <= RESET_REG;
            irq_enables_one  <= RESET_REG;
            irq_enables_two  <= RESET_REG;
        end else begin
            irq_enables_zero <= next_irq_enables_zero;
            irq_enables_one  <= next_irq_enables_one;
            irq_enables_two  <= next_irq_enables_two;
        end
    end

    // Status: write one clears, bank events set
    always_comb begin
        next_irq_status = irq_status;
        if (wr_status) begin
            next_irq_status = w1c(irq_status, pwdata[3:0]);
        end
        // Set beats clear
        next_irq_status = next_irq_status | events;                           // R8
    end

    // Status register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= RESET_STATUS;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // Mask as written
    always_comb begin
        next_irq_mask = irq_mask;
        if (wr_mask) begin
            next_irq_mask = pwdata[3:0];
        end
    end

    // Mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= RESET_STATUS;
        end else begin
            irq_mask <= next_irq_mask;
        end
    end

    // Bus answer one cycle after the access phase opens
    always_comb begin
        next_pready  = hit;
        next_pslverr = hit && !is_mapped(paddr);
        next_prdata  = 32'h0000_0000;
        if (rd_ok) begin
            case (paddr)
                OFS_FLAGS4: next_prdata = rd_word(flags_four_view);   // R1 R3
                OFS_EN0:    next_prdata = rd_word(irq_enables_zero);  // R2 R5
                OFS_EN1:    next_prdata = rd_word(irq_enables_one);   // R2 R6
                OFS_EN2:    next_prdata = rd_word(irq_enables_two);   // R2 R7
                OFS_STATUS: next_prdata = rd_nibble(irq_status);
                OFS_MASK:   next_prdata = rd_nibble(irq_mask);
                default:    next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Forward banks zero to two only flagged and enabled, flag four as flagged
    always_comb begin
        next_fwd_zero = z_sync & irq_enables_zero;  // R2 R8
        next_fwd_one  = o_sync & irq_enables_one;   // R2 R8
        next_fwd_two  = t_sync & irq_enables_two;   // R2 R8
        next_fwd_four = flags_four_view;            // R8
    end

    // Forward registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_zero <= RESET_REG;
            fwd_one  <= RESET_REG;
            fwd_two  <= RESET_REG;
            fwd_four <= RESET_REG;
        end else begin
            fwd_zero <= next_fwd_zero;
            fwd_one  <= next_fwd_one;
            fwd_two  <= next_fwd_two;
            fwd_four <= next_fwd_four;
        end
    end

    // Interrupt high while a masked status bit is set
    always_comb begin
        next_irq = |(next_irq_status & next_irq_mask);
    end

    // Interrupt register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end
endmodule : ifb_bank

// *** hw/ifb_pkg.sv ***
// Constants for the interrupt flag and enable bank.
// Assumes an APB master on pclk and level request inputs from peripherals.
// Summary of operation
// R1: Flag reads one once its request occurred
// R2: Enable bit one passes request, zero blocks
// R3: Unimplemented bit positions always read zero
// R4: Flag four layout bits seven to zero
// R5: Enable zero layout bits fourteen to zero
// R6: Enable one layout bits fifteen to zero
// R7: Enable two layout bits fifteen to zero
// R8: Forward banks zero to two only flagged and enabled, flag four as flagged; software clears
package ifb_pkg;
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] OFS_FLAGS4    = 12'h000;
    localparam logic [11:0] OFS_EN0       = 12'h004;
    localparam logic [11:0] OFS_EN1       = 12'h008;
    localparam logic [11:0] OFS_EN2       = 12'h00c;
    localparam logic [11:0] OFS_STATUS    = 12'h010;
    localparam logic [11:0] OFS_MASK      = 12'h014;
    localparam logic [15:0] MASK_FLAGS4   = 16'h00f7;
    localparam logic [15:0] MASK_EN0      = 16'h7fff;
    localparam logic [15:0] MASK_EN1      = 16'hfffb;
    localparam logic [15:0] MASK_EN2      = 16'hdfff;
    localparam logic [15:0] RESET_REG     = 16'h0000;
    localparam logic [3:0]  RESET_STATUS  = 4'h0;
    localparam int          BIT_CAN2_TX   = 7;
    localparam int          BIT_CAN1_TX   = 6;
    localparam int          BIT_DMA7      = 5;
    localparam int          BIT_DMA6      = 4;
    localparam int          BIT_UART2_ERR = 2;
    localparam int          BIT_UART1_ERR = 1;
    localparam int          BIT_FAULT_B   = 0;
endpackage : ifb_pkg

// *** hw/ifb_sync.sv ***
// Two-flop synchroniser for a bus of request inputs.
// Assumes inputs are asynchronous to pclk.
module ifb_sync #(
    parameter int W = 16
) (
    input  wire logic         pclk,     // Clock
    input  wire logic         presetn,  // Async reset, active low
    input  wire logic [W-1:0] din,      // Raw inputs
    output logic      [W-1:0] dout      // Synchronised outputs
);
    logic [W-1:0] stage1;
    // First stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule : ifb_sync

// *** hw/ifb_edge.sv ***
// Rising edge detector giving one-cycle pulses.
// Assumes inputs already on pclk.
module ifb_edge #(
    parameter int W = 16
) (
    input  wire logic         pclk,     // Clock
    input  wire logic         presetn,  // Async reset, active low
    input  wire logic [W-1:0] level,    // Synchronised levels
    output logic      [W-1:0] rise      // One-cycle rise pulses
);
    logic [W-1:0] prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= '0;
        end else begin
            prev <= level;
        end
    end
    // Pulse on low to high
    assign rise = level & ~prev;
endmodule : ifb_edge

// *** dv/ifb_src_model.sv ***
// Peripheral source model: request and flag levels.
// Assumes the bench changes wanted levels right after a clock edge.
module ifb_src_model (
    input  wire logic [15:0] set4,       // Wanted requests
    input  wire logic [15:0] src,        // Wanted flags
    output logic      [15:0] req_four,   // Flag-four requests
    output logic      [15:0] flags_zero, // Bank zero flags
    output logic      [15:0] flags_one,  // Bank one flags
    output logic      [15:0] flags_two   // Bank two flags
);
    // Spare positions are driven too
    assign req_four = set4;
    assign {flags_two, flags_one, flags_zero} = {3{src}};
endmodule : ifb_src_model

// *** dv/ifb_bank_asserts.sv ***
// Checker for the flag and enable bank.
// Assumes ifb_pkg is compiled first; one clock domain.
module ifb_bank_asserts
    import ifb_pkg::*;
(
    input wire logic [ADDR_W-1:0] paddr,      // Address
    input wire logic              pclk,       // Clock
    input wire logic              presetn,    // Reset
    input wire logic              pwrite,     // Direction
    input wire logic              pready,     // Ready
    input wire logic [31:0]       prdata,     // Read data
    input wire logic [15:0]       req_four,   // Requests
    input wire logic [15:0]       flags_zero, // Bank zero flags
    input wire logic [15:0]       fwd_zero,   // Forwarded zero
    input wire logic [15:0]       fwd_four    // Flag four
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed reads and flag-four writes
    wire rdx = pready && !pwrite;
    wire wr4 = pready && pwrite && paddr == OFS_FLAGS4;
    AST_RD_FLAGS4: assert property (rdx && paddr == OFS_FLAGS4 |-> (prdata & 32'hffff_ff08) == 32'h0)
        else $error("flag four spare bit");
    AST_RD_EN0: assert property (rdx && paddr == OFS_EN0 |-> prdata[31:15] == 17'h0)
        else $error("enable zero spare bit");
    AST_RD_EN1: assert property (rdx && paddr == OFS_EN1 |-> prdata[31:16] == 16'h0 && !prdata[2])
        else $error("enable one spare bit");
    AST_RD_EN2: assert property (rdx && paddr == OFS_EN2 |-> prdata[31:16] == 16'h0 && !prdata[13])
        else $error("enable two spare bit");
    AST_FWD_GATED: assert property (!fwd_zero[15] && (fwd_zero & ~($past(flags_zero, 2) | $past(flags_zero, 3)
        | $past(flags_zero, 4))) == 16'h0) else $error("forward without flag");
    AST_FWD4_SPARE: assert property ((fwd_four & 16'hff08) == 16'h0)
        else $error("flag four spare forwarded");
    AST_FLAG4_SET: assert property ($rose(req_four[BIT_FAULT_B]) |-> ##[1:8] fwd_four[BIT_FAULT_B])
        else $error("request edge set no flag");
    AST_FLAG4_HOLD: assert property (!$past(wr4) && !$past(wr4, 2) |-> ($past(fwd_four) & ~fwd_four) == 16'h0)
        else $error("flag dropped without write");
    // Main scenarios
    cover property (rdx && prdata != 32'h0);
    cover property ($fell(fwd_four[BIT_FAULT_B]));
    cover property (fwd_zero == 16'h7fff);
endmodule : ifb_bank_asserts
bind ifb_bank ifb_bank_asserts u_ifb_chk (.*);

// *** dv/test_irq_flag_enable_bank.sv ***
// Bench for the flag and enable bank: layout, flags, gating, interrupt, errors.
// Assumes ifb_pkg, ifb_bank, the model and the checker are compiled first.
module test_irq_flag_enable_bank;
    timeunit 1ns;
    timeprecision 1ns;
    import ifb_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, se;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [15:0] set4 = '0, src = '0, rq, fz, fo, ft, wz, wo, wt, w4;
    logic [15:0] msk [4] = '{16'h00f7, 16'h7fff, 16'hfffb, 16'hdfff};
    int          err_count = 0, checks = 0;
    // Clock and watchdog
    initial forever #25 pclk = ~pclk;
    initial begin
        #400000;
        err_count++;
        summarize();
    end
    ifb_src_model src_m (.set4(set4), .src(src), .req_four(rq), .flags_zero(fz), .flags_one(fo), .flags_two(ft));
    ifb_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_four(rq), .flags_zero(fz),
        .flags_one(fo), .flags_two(ft), .fwd_zero(wz), .fwd_one(wo), .fwd_two(wt), .fwd_four(w4), .irq(irq));
    // Compare and count
    task automatic chk(string n, logic [47:0] s, logic [47:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One APB transfer, entered just after an edge
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb
    // Reset values, then all ones shows each layout
    task automatic t_regs;
        for (int i = 0; i < 4; i++) begin
            apb(0, 12'(4 * i), 32'h0);
            chk("reset", rd, 0);
            apb(1, 12'(4 * i), 32'hffff_ffff);
            apb(0, 12'(4 * i), 32'h0);
            chk("layout", rd, msk[i]);
            apb(1, 12'(4 * i), 32'h0);
        end
    endtask : t_regs
    // Edges set sticky flags, a written value clears
    task automatic t_flags;
        set4 <= 16'hffff;
        repeat (8) @(posedge pclk);
        set4 <= 16'h0000;
        repeat (8) @(posedge pclk);
        apb(0, OFS_FLAGS4, 32'h0);
        chk("flags4", rd, 32'h00f7);
        chk("fwd4", w4, 16'h00f7);
        apb(1, OFS_FLAGS4, 32'h0081);
        apb(0, OFS_FLAGS4, 32'h0);
        chk("flags4 clear", rd, 32'h0081);
        apb(1, OFS_FLAGS4, 32'h0);
    endtask : t_flags
    // Enables pass or block, interrupt raised and cleared
    task automatic t_gate;
        src <= 16'hffff;
        apb(1, OFS_MASK, 32'h2);
        for (int i = 1; i < 4; i++) apb(1, 12'(4 * i), 32'hffff);
        repeat (6) @(posedge pclk);
        chk("fwd", {wt, wo, wz}, {16'hdfff, 16'hfffb, 16'h7fff});
        chk("irq", irq, 1);
        for (int i = 1; i < 4; i++) apb(1, 12'(4 * i), 32'h0);
        repeat (6) @(posedge pclk);
        chk("blocked", {wt, wo, wz}, 0);
        src <= 16'h0000;
        repeat (6) @(posedge pclk);
        apb(0, OFS_STATUS, 32'h0);
        chk("status set", rd, 32'hf);
        apb(1, OFS_MASK, 32'h0);
        chk("irq masked", irq, 0);
        apb(1, OFS_MASK, 32'h1);
        chk("irq flag four", irq, 1);
        apb(1, OFS_STATUS, 32'hf);
        apb(0, OFS_STATUS, 32'h0);
        chk("status", rd, 0);
        chk("irq off", irq, 0);
    endtask : t_gate
    // Unmapped place refuses and reads zero
    task automatic t_bad;
        apb(1, 12'h040, 32'hffff_ffff);
        chk("slverr", se, 1);
        apb(0, 12'h040, 32'h0);
        chk("unmapped", {se, rd}, 33'h1_0000_0000);
    endtask : t_bad
    // Verdict
    task automatic summarize;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    // Main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_regs();
        t_flags();
        t_gate();
        t_bad();
        summarize();
    end
endmodule : test_irq_flag_enable_bank
